/* File: design/acs_pkg.sv */
// constants for the analog comparator status block
package acs_pkg;
  // register byte addresses
  localparam logic [7:0] ACS_FLAG_STATE_ADDR = 8'h00;
  localparam logic [7:0] ACS_CONTROL_ADDR = 8'h04;
  // analog_flag_state field positions
  localparam int ACS_FS_B_FLAG = 7;
  localparam int ACS_FS_A_FLAG = 6;
  localparam int ACS_FS_B_CLR = 5;
  localparam int ACS_FS_A_CLR = 4;
  localparam int ACS_FS_OFFSET = 3;
  localparam int ACS_FS_PIN_ROUTE = 2;
  localparam int ACS_FS_B_LIVE = 1;
  localparam int ACS_FS_A_LIVE = 0;
  // analog_control_register field positions
  localparam int ACS_CR_CHARGE = 7;
  localparam int ACS_CR_MODE_B = 6;
  localparam int ACS_CR_MODE_A = 5;
  localparam int ACS_CR_CAPTURE_EN = 4;
  localparam int ACS_CR_IRQ_EN = 3;
  localparam int ACS_CR_COMP_B_EN = 2;
  localparam int ACS_CR_COMP_A_EN = 1;
  localparam int ACS_CR_ISRC_EN = 0;
  // values after reset
  localparam logic [7:0] ACS_CONTROL_RESET = 8'h00;
  localparam logic ACS_BIT_RESET = 1'b0;
  localparam logic [2:0] ACS_SYNC_RESET = 3'h0;
  localparam logic [31:0] ACS_RDATA_RESET = 32'h00000000;
  // number of comparators handled
  localparam int ACS_NUM_COMP = 2;
  localparam int ACS_COMP_A = 0;
  localparam int ACS_COMP_B = 1;
endpackage

/* File: design/acs_top.sv */
// analog comparator flags, live state, option bits and charge gating
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Function
// - comparator b rising edge sets its event flag; held until cleared.
// - comparator a rising edge sets its event flag; held until cleared.
// - flags and live bits use raw comparator outputs, ignoring polarity invert.
// - writing 1 to comparator b clear strobe clears its flag; 0 does nothing.
// - writing 1 to comparator a clear strobe clears its flag; 0 does nothing.
// - clear strobes are write-only and always read zero.
// - reset clears both flags, offset enable and pin route enable.
// - offset enable works only with option bit set; otherwise reads zero.
// - offset applied only with offset enabled and both sample connects clear.
// - pin route enable works only with option bit set; otherwise reads zero.
// - routed pin drives OR of comparator a, port data and level bit.
// - comparator b live bit shows present comparator b state, unlatched.
// - comparator a live bit shows present comparator a state, unlatched.
// - live bits read zero after reset until comparators enabled.
// - top control bit selects charge or discharge only with current source enabled.
// - clearing current source enable stops charge and discharge at once.
// - after reset charge and discharge are both disabled.
// - with interrupt enable set, either flag set requests analog interrupt.
module acs_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparator outputs, asynchronous
  input wire logic comp_a_raw,
  input wire logic comp_b_raw,
  // option and neighbour register bits
  input wire logic extra_features_option,
  input wire logic sample_connect_a,
  input wire logic sample_connect_b,
  input wire logic port_b4_direction,
  input wire logic port_b4_data,
  input wire logic timer_output_level,
  // analog switch controls
  output logic sample_offset_drive,
  output logic charge_source_on,
  output logic discharge_on,
  output logic comp_a_power,
  output logic comp_b_power,
  // port b bit 4 pin
  output logic port_b_bit4_out,
  output logic port_b_bit4_oe,
  // status to the rest of the chip
  output logic comp_b_capture,
  output logic analog_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // comparator synchronisers and edge detection

  // one lane per comparator
  localparam int ACS_NUM_COMP_W = acs_pkg::ACS_NUM_COMP;

  logic [ACS_NUM_COMP_W-1:0] raw_in;
  logic [2:0] sync_r [ACS_NUM_COMP_W];
  logic [2:0] sync_nxt [ACS_NUM_COMP_W];
  logic [ACS_NUM_COMP_W-1:0] stable_r;
  logic [ACS_NUM_COMP_W-1:0] stable_nxt;
  logic [ACS_NUM_COMP_W-1:0] comp_en;
  logic [ACS_NUM_COMP_W-1:0] live;
  logic [ACS_NUM_COMP_W-1:0] rise;
  logic [ACS_NUM_COMP_W-1:0] flag_r;
  logic [ACS_NUM_COMP_W-1:0] flag_nxt;
  logic [ACS_NUM_COMP_W-1:0] clr_strobe;

  // register state
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic offset_r;
  logic offset_nxt;
  logic route_r;
  logic route_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // pin drive state
  logic pin_out_r;
  logic pin_out_nxt;
  logic pin_oe_r;
  logic pin_oe_nxt;

  // bus decode and masked views
  logic setup_ph;
  logic wr_acc;
  logic sel_flag;
  logic sel_ctrl;
  logic lane0;
  logic offset_eff;
  logic route_eff;
  logic [7:0] flag_state_rd;

  assign raw_in[acs_pkg::ACS_COMP_A] = comp_a_raw;
  assign raw_in[acs_pkg::ACS_COMP_B] = comp_b_raw;
  assign comp_en[acs_pkg::ACS_COMP_A] = ctrl_r[acs_pkg::ACS_CR_COMP_A_EN];
  assign comp_en[acs_pkg::ACS_COMP_B] = ctrl_r[acs_pkg::ACS_CR_COMP_B_EN];
  // clear strobes are one-cycle pulses, never stored
  assign clr_strobe[acs_pkg::ACS_COMP_A] =
    wr_acc & sel_flag & lane0 & pwdata[acs_pkg::ACS_FS_A_CLR];
  assign clr_strobe[acs_pkg::ACS_COMP_B] =
    wr_acc & sel_flag & lane0 & pwdata[acs_pkg::ACS_FS_B_CLR];

  genvar gi;
  generate
    for (gi = 0; gi < ACS_NUM_COMP_W; gi++) begin : g_comp
      // three stages; a change counts once stages two and three agree
      always_comb begin
        sync_nxt[gi] = {sync_r[gi][1:0], raw_in[gi]};
        stable_nxt[gi] = stable_r[gi];
        if (sync_r[gi][1] == sync_r[gi][2]) begin
          stable_nxt[gi] = sync_r[gi][2];
        end
      end

      // powered-down comparator reads low
      assign live[gi] = stable_r[gi] & comp_en[gi];
      // first settled high while powered counts as an event
      assign rise[gi] = comp_en[gi] & ~stable_r[gi] &
                        sync_r[gi][1] & sync_r[gi][2];

      // set beats clear
      always_comb begin
        flag_nxt[gi] = flag_r[gi];
        if (clr_strobe[gi]) begin
          flag_nxt[gi] = 1'b0;
        end
        if (rise[gi]) begin
          flag_nxt[gi] = 1'b1;
        end
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          sync_r[gi] <= acs_pkg::ACS_SYNC_RESET;
          stable_r[gi] <= acs_pkg::ACS_BIT_RESET;
        end else begin
          sync_r[gi] <= sync_nxt[gi];
          stable_r[gi] <= stable_nxt[gi];
        end
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          flag_r[gi] <= acs_pkg::ACS_BIT_RESET;
        end else begin
          flag_r[gi] <= flag_nxt[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // apb decode and register writes

  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign sel_flag = (paddr == acs_pkg::ACS_FLAG_STATE_ADDR);
  assign sel_ctrl = (paddr == acs_pkg::ACS_CONTROL_ADDR);
  assign lane0 = pstrb[0];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(sel_flag | sel_ctrl);

  assign offset_eff = offset_r & extra_features_option;
  assign route_eff = route_r & extra_features_option;

  //////////////////////////////////////////////////////////////////////////////
  // flag and state register read view

  always_comb begin
    flag_state_rd = 8'h00;
    flag_state_rd[acs_pkg::ACS_FS_B_FLAG] = flag_r[acs_pkg::ACS_COMP_B];
    flag_state_rd[acs_pkg::ACS_FS_A_FLAG] = flag_r[acs_pkg::ACS_COMP_A];
    // strobe positions always read low
    flag_state_rd[acs_pkg::ACS_FS_B_CLR] = 1'b0;
    flag_state_rd[acs_pkg::ACS_FS_A_CLR] = 1'b0;
    flag_state_rd[acs_pkg::ACS_FS_OFFSET] = offset_eff;
    flag_state_rd[acs_pkg::ACS_FS_PIN_ROUTE] = route_eff;
    flag_state_rd[acs_pkg::ACS_FS_B_LIVE] = live[acs_pkg::ACS_COMP_B];
    flag_state_rd[acs_pkg::ACS_FS_A_LIVE] = live[acs_pkg::ACS_COMP_A];
  end

  //////////////////////////////////////////////////////////////////////////////
  // register storage

  // control register
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_acc && lane0 && sel_ctrl) begin
      ctrl_nxt = pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= acs_pkg::ACS_CONTROL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // stored even while the option is clear; effect and reads masked
  always_comb begin
    offset_nxt = offset_r;
    route_nxt = route_r;
    if (wr_acc && lane0 && sel_flag) begin
      offset_nxt = pwdata[acs_pkg::ACS_FS_OFFSET];
      route_nxt = pwdata[acs_pkg::ACS_FS_PIN_ROUTE];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      offset_r <= acs_pkg::ACS_BIT_RESET;
      route_r <= acs_pkg::ACS_BIT_RESET;
    end else begin
      offset_r <= offset_nxt;
      route_r <= route_nxt;
    end
  end

  // read data captured in setup, presented during access
  always_comb begin
    rdata_nxt = rdata_r;
    if (setup_ph && !pwrite) begin
      if (sel_flag) begin
        rdata_nxt = {24'h000000, flag_state_rd};
      end else if (sel_ctrl) begin
        rdata_nxt = {24'h000000, ctrl_r};
      end else begin
        rdata_nxt = acs_pkg::ACS_RDATA_RESET;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= acs_pkg::ACS_RDATA_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // prdata straight from a flop
  assign prdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // port b bit 4 pin

  // registered so decode glitches never reach the pin
  always_comb begin
    pin_oe_nxt = port_b4_direction;
    pin_out_nxt = port_b4_data | timer_output_level |
                  (route_eff & live[acs_pkg::ACS_COMP_A]);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_out_r <= acs_pkg::ACS_BIT_RESET;
      pin_oe_r <= acs_pkg::ACS_BIT_RESET;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign port_b_bit4_out = pin_out_r;
  assign port_b_bit4_oe = pin_oe_r;

  //////////////////////////////////////////////////////////////////////////////
  // analog switch controls and status

  // offset only while the sample capacitor floats free of inputs
  assign sample_offset_drive = offset_eff & ~sample_connect_a &
                               ~sample_connect_b;
  // no sequencing: source enable gates both switches directly
  assign charge_source_on = ctrl_r[acs_pkg::ACS_CR_ISRC_EN] &
                            ctrl_r[acs_pkg::ACS_CR_CHARGE];
  assign discharge_on = ctrl_r[acs_pkg::ACS_CR_ISRC_EN] &
                        ~ctrl_r[acs_pkg::ACS_CR_CHARGE];

  //////////////////////////////////////////////////////////////////////////////
  // comparator power and timer capture

  assign comp_a_power = ctrl_r[acs_pkg::ACS_CR_COMP_A_EN];
  assign comp_b_power = ctrl_r[acs_pkg::ACS_CR_COMP_B_EN];
  // capture path to the timer when enabled
  assign comp_b_capture = ctrl_r[acs_pkg::ACS_CR_CAPTURE_EN] &
                          flag_r[acs_pkg::ACS_COMP_B];

  //////////////////////////////////////////////////////////////////////////////
  // analog interrupt request

  assign analog_irq = ctrl_r[acs_pkg::ACS_CR_IRQ_EN] & (|flag_r);

endmodule

`default_nettype wire

/* File: sim/acs_top_asserts.sv */
// port checks for the analog comparator status block
`timescale 1ns/1ps
`default_nettype none

module acs_top_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  // neighbour bits
  input wire logic extra_features_option,
  input wire logic sample_connect_a,
  input wire logic sample_connect_b,
  input wire logic port_b4_data,
  input wire logic timer_output_level,
  // outputs watched
  input wire logic sample_offset_drive,
  input wire logic charge_source_on,
  input wire logic discharge_on,
  input wire logic port_b_bit4_out,
  input wire logic analog_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  //////////////////////////////////////////////////////////////////////////////
  sequence acc_s;
    psel && penable;
  endsequence
  sequence flag_rd_s;
    acc_s ##0 (!pwrite && paddr == 8'h00);
  endsequence

  strobe_zero_a: assert property (flag_rd_s |-> prdata[5:4] == 2'b00)
    else $error("clear strobe bits read back set");
  opt_mask_a: assert property (flag_rd_s ##0 !$past(extra_features_option) |->
    prdata[3:2] == 2'b00)
    else $error("option gated bits read set with option clear");
  offset_gate_a: assert property (sample_offset_drive |->
    extra_features_option && !sample_connect_a && !sample_connect_b)
    else $error("offset driven while gated off");
  charge_excl_a: assert property (!(charge_source_on && discharge_on))
    else $error("charge and discharge on together");
  reset_idle_a: assert property ($rose(resetn) |->
    !charge_source_on && !discharge_on && !analog_irq)
    else $error("analog controls active after reset");
  pin_or_a: assert property (port_b4_data || timer_output_level |=> port_b_bit4_out)
    else $error("pin output misses data or level");
  irq_hold_a: assert property (analog_irq && !(psel && penable && pwrite) |=>
    analog_irq)
    else $error("interrupt dropped without a write");
  apb_resp_a: assert property (acc_s |->
    pready && (pslverr == (paddr != 8'h00 && paddr != 8'h04)))
    else $error("wrong apb response");
endmodule

bind acs_top acs_top_asserts chk_u (.sys_clk, .resetn, .psel, .penable, .pwrite, .pready,
  .pslverr, .paddr, .prdata, .extra_features_option, .sample_connect_a, .sample_connect_b,
  .port_b4_data, .timer_output_level, .sample_offset_drive, .charge_source_on, .discharge_on,
  .port_b_bit4_out, .analog_irq);

`default_nettype wire

/* File: sim/acs_comp_model.sv */
// comparator outputs facing the block
`timescale 1ns/1ps
`default_nettype none

module acs_comp_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // wanted levels and power, index 0 is comparator a
  input wire logic [1:0] above,
  input wire logic [1:0] power,
  // raw outputs
  output logic [1:0] raw
);
  logic [1:0] wander_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wander_r <= 2'b01;
    end else begin
      wander_r <= ~wander_r;
    end
  end
  // unpowered comparators are indeterminate
  assign raw = (power & above) | (~power & wander_r);
endmodule

`default_nettype wire

/* File: sim/analog_comparator_status_tb_top.sv */
// self-checking bench for the analog comparator status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin #1; tests_run++; if ((s) !== (e)) begin err_count++; \
  $display("unexpected %s: expected %h seen %h", n, e, s); end end

module analog_comparator_status_tb_top;
  logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic extra_features_option = 1'b0, sample_connect_a = 1'b0, sample_connect_b = 1'b0;
  logic port_b4_direction = 1'b0, port_b4_data = 1'b0, timer_output_level = 1'b0;
  logic [1:0] above = 2'b00;
  wire logic comp_a_raw, comp_b_raw;
  logic pready, pslverr, sample_offset_drive, charge_source_on, discharge_on, err;
  logic comp_a_power, comp_b_power, port_b_bit4_out, port_b_bit4_oe, comp_b_capture, analog_irq;
  logic [7:0] ctl [4] = '{8'h80, 8'h81, 8'h01, 8'h80};
  logic [1:0] cx [4] = '{2'b00, 2'b10, 2'b01, 2'b00};
  int err_count = 0, tests_run = 0, cyc = 0;

  acs_top dut_u (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .comp_a_raw, .comp_b_raw, .extra_features_option, .sample_connect_a,
    .sample_connect_b, .port_b4_direction, .port_b4_data, .timer_output_level,
    .sample_offset_drive, .charge_source_on, .discharge_on, .comp_a_power, .comp_b_power,
    .port_b_bit4_out, .port_b_bit4_oe, .comp_b_capture, .analog_irq);
  acs_comp_model model_u (.sys_clk, .resetn, .above, .power({comp_b_power, comp_a_power}),
    .raw({comp_b_raw, comp_a_raw}));

  //////////////////////////////////////////////////////////////////////////////
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `CHK("flags after reset", 32'h00000000, rd)
    apb(1'b0, 8'h04, 32'h0);
    `CHK("control after reset", 32'h00000000, rd)
    `CHK("charge after reset", 2'b00, {charge_source_on, discharge_on})
    apb(1'b1, 8'h04, 32'h0000001E);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("control readback", 32'h0000001E, rd)
    `CHK("comparator power", 2'b11, {comp_b_power, comp_a_power})
    repeat (4) @(posedge sys_clk);
    apb(1'b1, 8'h00, 32'h00000030);
    for (int i = 0; i < 2; i++) begin
      above[i] <= 1'b1;
      repeat (5) @(posedge sys_clk);
      apb(1'b0, 8'h00, 32'h0);
      `CHK("event and live", 32'h00000041 << i, rd)
      `CHK("interrupt set", 1'b1, analog_irq)
      `CHK("timer capture", 1'(i), comp_b_capture)
      above[i] <= 1'b0;
      repeat (5) @(posedge sys_clk);
      apb(1'b1, 8'h00, 32'h00000020 >> i);
      apb(1'b0, 8'h00, 32'h0);
      `CHK("event held", 32'h00000040 << i, rd)
      apb(1'b1, 8'h00, 32'h00000010 << i);
      apb(1'b0, 8'h00, 32'h0);
      `CHK("event cleared", 32'h00000000, rd)
      `CHK("interrupt clear", 1'b0, analog_irq)
    end
    above[0] <= 1'b1;
    @(posedge sys_clk);
    apb(1'b1, 8'h00, 32'h00000010);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("edge beside clear", 32'h00000041, rd)
    extra_features_option <= 1'b1;
    port_b4_direction <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000000C);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("option bits", 32'h0000004D, rd)
    `CHK("offset drive", 1'b1, sample_offset_drive)
    `CHK("routed pin", 1'b1, port_b_bit4_out)
    `CHK("pin enable", 1'b1, port_b_bit4_oe)
    sample_connect_b <= 1'b1;
    `CHK("offset while held", 1'b0, sample_offset_drive)
    extra_features_option <= 1'b0;
    timer_output_level <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `CHK("option masked", 32'h00000041, rd)
    foreach (ctl[k]) begin
      apb(1'b1, 8'h04, {24'h000000, ctl[k]});
      `CHK("charge and discharge", cx[k], {charge_source_on, discharge_on})
    end
    apb(1'b1, 8'h08, 32'h000000FF);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h00000000, rd)
    resetn <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `CHK("flags after second reset", 32'h00000000, rd)
    wrap_up();
  end
endmodule

`default_nettype wire
